// ===== jfp_top.sv
`timescale 1ns/1ps
`include "jfp_consts.svh"

// Function
// - Command-entry instruction selects the 15-bit command register.
// - Capture-DR with command entry loads the previous command result.
// - Shift-DR shifts command register one bit per TCK, result out, command in.
// - Update-DR with command entry presents the new command to flash.
// - Run-Test/Idle after an update gives one execute clock.
// - Page-load selects a 1024-bit virtual chain over an 8-bit shifter.
// - Page load ignores Update-DR; each shifted byte goes to page buffer.
// - Page-read selects a 1032-bit virtual chain over an 8-bit shifter.
// - Page read skips Capture-DR, fetches bytes automatically, ignores TDI.
// - A one in the part-reset register holds the part in reset.
// - After clearing, reset lasts the fuse-selected time-out period.
// - Part-reset output is not latched at Update-DR; acts immediately.
// - Programming allowed only while enable register equals the signature.
// - Enable register clears at power-on; programmer clears it when leaving.
// - Every shift register shifts least significant bit first.
// - Instruction register is four bits wide.
// - Unlock Update-DR compares shifted value, enters programming on match.
// - Part-reset instruction selects one-bit register, TAP not reset.
module jfp_top #(
    parameter int TOUT_SHORT_CYC = `JFP_TOUT_SHORT_US * `JFP_CLK_MHZ,
    parameter int TOUT_LONG_CYC  = `JFP_TOUT_LONG_US * `JFP_CLK_MHZ
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 tck,
    input  wire logic                 tdi,
    input  wire jfp_pkg::jfp_ir_t     ir,
    input  wire logic                 capture_dr,
    input  wire logic                 shift_dr,
    input  wire logic                 update_dr,
    input  wire logic                 run_idle,
    input  wire logic                 tout_fuse,
    input  wire logic [`JFP_CMD_W-1:0] cmd_result,
    input  wire logic                 cmd_result_vld,
    output logic                      tdo,
    output logic                      tdo_oe,
    output logic                      part_reset,
    output logic                      prog_mode,
    output logic [`JFP_CMD_W-1:0]     cmd_word,
    output logic                      cmd_exec
);
    import jfp_pkg::*;

    logic                  rst_tck_n;
    logic                  sel_prst, sel_unlock, sel_cmd, sel_pld, sel_prd;
    logic                  prst_r;
    logic [`JFP_EN_W-1:0]  en_sh_r, en_reg_r;
    logic                  unlock_r;
    logic [`JFP_CMD_W-1:0] cmd_sh_r, cmd_hold_r, res_tck_r, res_hold_r;
    logic                  upd_pend_r, upd_tgl_r, exec_tgl_r;
    logic                  res_tgl_r, res_tgl_s, res_seen_r;
    jfp_pg_e               pg_r, pg_nxt;
    logic [2:0]            bit_cnt_r;
    logic [`JFP_IDX_W-1:0] idx_r;
    logic [7:0]            pg_sh_r, rd_data;
    logic                  byte_done, pg_we, tdo_nxt, oe_nxt;
    logic [3:0]            lvl_src, lvl_s;
    logic [1:0]            seen_r;
    logic                  prst_s;
    logic [`JFP_TOUT_W-1:0] tout_cnt_r, tout_cyc;

    // Tells whether the loaded instruction selects a given register.
    function automatic logic dr_is(input jfp_ir_t v, input jfp_ir_t code);
        return v == code;
    endfunction

    // ------------------------------------------------------------------
    // Instruction decode and reset of the TCK side
    // ------------------------------------------------------------------
    // The TCK-side reset releases in step with TCK.
    jfp_sync u_tck_rst (
        .clk   (tck),
        .rst_n (rst_n),
        .d     (1'b1),
        .q     (rst_tck_n)
    );

    // Four-bit instruction code picks the data register.
    assign sel_prst   = dr_is(ir, `JFP_IR_PRST);
    assign sel_unlock = dr_is(ir, `JFP_IR_UNLOCK);
    assign sel_cmd    = dr_is(ir, `JFP_IR_CMD);
    assign sel_pld    = dr_is(ir, `JFP_IR_PLOAD);
    assign sel_prd    = dr_is(ir, `JFP_IR_PREAD);

    // ------------------------------------------------------------------
    // Part-reset register
    // ------------------------------------------------------------------
    // One bit, shifted directly; no update latch sits behind it.
    always_ff @(posedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            prst_r <= 1'b0;
        end else if (shift_dr && sel_prst) begin
            prst_r <= tdi;
        end
    end

    // ------------------------------------------------------------------
    // Programming enable register
    // ------------------------------------------------------------------
    // Signature shifts in LSB first and is judged at Update-DR.
    always_ff @(posedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            en_sh_r  <= 16'h0000;
            en_reg_r <= 16'h0000;
            unlock_r <= 1'b0;
        end else if (shift_dr && sel_unlock) begin
            en_sh_r <= {tdi, en_sh_r[`JFP_EN_W-1:1]};
        end else if (update_dr && sel_unlock) begin
            en_reg_r <= en_sh_r;
            unlock_r <= (en_sh_r == `JFP_SIG);
        end
    end

    // ------------------------------------------------------------------
    // Programming command register
    // ------------------------------------------------------------------
    // Capture takes the last result, shift moves one bit per TCK.
    always_ff @(posedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            cmd_sh_r <= 15'h0000;
        end else if (capture_dr && sel_cmd) begin
            cmd_sh_r <= res_tck_r;
        end else if (shift_dr && sel_cmd) begin
            cmd_sh_r <= {tdi, cmd_sh_r[`JFP_CMD_W-1:1]};
        end
    end

    // Update applies the command; Run-Test/Idle then fires one execute.
    always_ff @(posedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            cmd_hold_r <= 15'h0000;
            upd_pend_r <= 1'b0;
            upd_tgl_r  <= 1'b0;
            exec_tgl_r <= 1'b0;
        end else if (update_dr && sel_cmd && unlock_r) begin
            cmd_hold_r <= cmd_sh_r;
            upd_tgl_r  <= ~upd_tgl_r;
            upd_pend_r <= 1'b1;
        end else if (run_idle && upd_pend_r) begin
            exec_tgl_r <= ~exec_tgl_r;
            upd_pend_r <= 1'b0;
        end
    end

    // Result word crosses from the system clock by a toggle handshake.
    jfp_sync u_res_sync (
        .clk   (tck),
        .rst_n (rst_tck_n),
        .d     (res_tgl_r),
        .q     (res_tgl_s)
    );

    // The held word is stable by the time the toggle arrives.
    always_ff @(posedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            res_seen_r <= 1'b0;
            res_tck_r  <= 15'h0000;
        end else if (res_tgl_s != res_seen_r) begin
            res_seen_r <= res_tgl_s;
            res_tck_r  <= res_hold_r;
        end
    end

    // ------------------------------------------------------------------
    // Page load and page read engine
    // ------------------------------------------------------------------
    // The engine arms at Capture-DR and returns to idle at Update-DR.
    always_comb begin
        pg_nxt = pg_r;
        case (pg_r)
            JFP_PG_IDLE: begin
                if (capture_dr && unlock_r && sel_pld) begin
                    pg_nxt = JFP_PG_LOAD;
                end else if (capture_dr && unlock_r && sel_prd) begin
                    pg_nxt = JFP_PG_READ;
                end
            end
            JFP_PG_LOAD, JFP_PG_READ: begin
                if (update_dr || !(sel_pld || sel_prd)) begin
                    pg_nxt = JFP_PG_IDLE;
                end
            end
            default: pg_nxt = JFP_PG_IDLE;
        endcase
    end

    // Holds the engine state.
    always_ff @(posedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            pg_r <= JFP_PG_IDLE;
        end else begin
            pg_r <= pg_nxt;
        end
    end

    assign byte_done = shift_dr && (pg_r != JFP_PG_IDLE) &&
                       (bit_cnt_r == `JFP_BIT_LAST);
    assign pg_we     = byte_done && (pg_r == JFP_PG_LOAD);

    // Bit and byte counters restart at every scan entry.
    always_ff @(posedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            bit_cnt_r <= 3'h0;
            idx_r     <= 7'h00;
        end else if (capture_dr) begin
            bit_cnt_r <= 3'h0;
            idx_r     <= 7'h00;
        end else if (shift_dr && pg_r != JFP_PG_IDLE) begin
            bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
            if (byte_done) begin
                idx_r <= 7'(idx_r + 7'h01);
            end
        end
    end

    // Eight-bit shifter; read mode reloads it and drops TDI.
    always_ff @(posedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            pg_sh_r <= 8'h00;
        end else if (shift_dr && pg_r == JFP_PG_LOAD) begin
            pg_sh_r <= {tdi, pg_sh_r[7:1]};
        end else if (shift_dr && pg_r == JFP_PG_READ) begin
            pg_sh_r <= byte_done ? rd_data : {1'b0, pg_sh_r[7:1]};
        end
    end

    jfp_page_ram u_page (
        .clk   (tck),
        .rst_n (rst_tck_n),
        .we    (pg_we),
        .waddr (idx_r),
        .wdata ({tdi, pg_sh_r[7:1]}),
        .raddr (idx_r),
        .rdata (rd_data)
    );

    // ------------------------------------------------------------------
    // Test data output
    // ------------------------------------------------------------------
    // Selects the low bit of the chosen register.
    always_comb begin
        tdo_nxt = 1'b0;
        oe_nxt  = shift_dr;
        case (1'b1)
            sel_prst:   tdo_nxt = prst_r;
            sel_unlock: tdo_nxt = en_sh_r[0];
            sel_cmd:    tdo_nxt = cmd_sh_r[0];
            sel_pld:    tdo_nxt = pg_sh_r[0];
            sel_prd:    tdo_nxt = pg_sh_r[0];
            default:    oe_nxt  = 1'b0;
        endcase
    end

    // TDO changes on the falling edge of TCK, as the scan chain expects.
    always_ff @(negedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo    <= tdo_nxt;
            tdo_oe <= oe_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the system clock
    // ------------------------------------------------------------------
    assign lvl_src = {exec_tgl_r, upd_tgl_r, unlock_r, prst_r};

    // One synchroniser per level or toggle.
    for (genvar g = 0; g < 4; g++) begin : g_sync
        jfp_sync u_sync (
            .clk   (clk),
            .rst_n (rst_n),
            .d     (lvl_src[g]),
            .q     (lvl_s[g])
        );
    end

    assign prst_s    = lvl_s[0];
    assign prog_mode = lvl_s[1];

    // Update toggles load the command word; execute toggles pulse once.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_r   <= 2'b00;
            cmd_word <= 15'h0000;
            cmd_exec <= 1'b0;
        end else begin
            seen_r   <= lvl_s[3:2];
            cmd_exec <= lvl_s[3] != seen_r[1];
            if (lvl_s[2] != seen_r[0]) begin
                cmd_word <= cmd_hold_r;
            end
        end
    end

    // Result word is held steady for the TCK side to pick up.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_hold_r <= 15'h0000;
            res_tgl_r  <= 1'b0;
        end else if (cmd_result_vld) begin
            res_hold_r <= cmd_result;
            res_tgl_r  <= ~res_tgl_r;
        end
    end

    // ------------------------------------------------------------------
    // Reset time-out
    // ------------------------------------------------------------------
    assign tout_cyc = tout_fuse ? `JFP_TOUT_W'(TOUT_LONG_CYC)
                                : `JFP_TOUT_W'(TOUT_SHORT_CYC);

    // Reloads while the register holds a one, then counts down.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tout_cnt_r <= 24'h000000;
        end else if (prst_s) begin
            tout_cnt_r <= tout_cyc;
        end else if (tout_cnt_r != 24'h000000) begin
            tout_cnt_r <= 24'(tout_cnt_r - 24'h000001);
        end
    end

    // The raw register bit acts at once; the rest stretches the release.
    assign part_reset = prst_r | prst_s | (tout_cnt_r != 24'h000000);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_cmd_shift;
        @(posedge tck) disable iff (!rst_tck_n)
        shift_dr && sel_cmd && !capture_dr |=>
            cmd_sh_r == {$past(tdi), $past(cmd_sh_r[14:1])};
    endproperty
    a_cmd_shift: assert property (p_cmd_shift)
        else $error("command register did not shift LSB first");

    property p_cmd_capture;
        @(posedge tck) disable iff (!rst_tck_n)
        capture_dr && sel_cmd |=> cmd_sh_r == $past(res_tck_r);
    endproperty
    a_cmd_capture: assert property (p_cmd_capture)
        else $error("capture did not load the previous result");

    property p_cmd_update;
        @(posedge tck) disable iff (!rst_tck_n)
        update_dr && sel_cmd && unlock_r |=>
            cmd_hold_r == $past(cmd_sh_r) && upd_pend_r;
    endproperty
    a_cmd_update: assert property (p_cmd_update)
        else $error("update did not apply the shifted command");

    property p_exec_once;
        @(posedge tck) disable iff (!rst_tck_n)
        (exec_tgl_r != $past(exec_tgl_r)) |->
            $past(run_idle && upd_pend_r && !(update_dr && sel_cmd));
    endproperty
    a_exec_once: assert property (p_exec_once)
        else $error("execute toggle without a pending update");

    property p_unlock;
        @(posedge tck) disable iff (!rst_tck_n)
        update_dr && sel_unlock && !shift_dr |=>
            unlock_r == ($past(en_sh_r) == `JFP_SIG);
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock did not follow the signature compare");

    property p_load_write;
        @(posedge tck) disable iff (!rst_tck_n)
        pg_we |-> bit_cnt_r == 3'h7 && shift_dr && unlock_r;
    endproperty
    a_load_write: assert property (p_load_write)
        else $error("page write outside the eighth shift");

    property p_read_load;
        @(posedge tck) disable iff (!rst_tck_n)
        byte_done && pg_r == JFP_PG_READ |=> pg_sh_r == $past(rd_data);
    endproperty
    a_read_load: assert property (p_read_load)
        else $error("page read shifter not reloaded from buffer");

    property p_idx_start;
        @(posedge tck) disable iff (!rst_tck_n)
        capture_dr ##1 (shift_dr && pg_r != JFP_PG_IDLE)[*8] |=>
            idx_r == 7'h01 && bit_cnt_r == 3'h0;
    endproperty
    a_idx_start: assert property (p_idx_start)
        else $error("byte index did not advance after eight shifts");

    property p_prst_now;
        @(posedge tck) disable iff (!rst_tck_n)
        prst_r |-> part_reset;
    endproperty
    a_prst_now: assert property (p_prst_now)
        else $error("part reset not active with register set");

    property p_tout_hold;
        @(posedge clk) disable iff (!rst_n)
        $fell(prst_s) && !prst_r |-> part_reset[*4];
    endproperty
    a_tout_hold: assert property (p_tout_hold)
        else $error("reset released before the time-out");

    c_exec: cover property (@(posedge clk) disable iff (!rst_n) cmd_exec);
    c_load: cover property (@(posedge tck) disable iff (!rst_tck_n) pg_we);
    c_read: cover property (@(posedge tck) disable iff (!rst_tck_n)
        byte_done && pg_r == JFP_PG_READ);
    c_unlock: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(prog_mode));
endmodule

// ===== jfp_consts.svh
`ifndef JFP_CONSTS_SVH
`define JFP_CONSTS_SVH

// ----------------------------------------------------------------------
// Instruction codes of the 4-bit instruction register
// ----------------------------------------------------------------------
`define JFP_IR_UNLOCK      4'h4
`define JFP_IR_CMD         4'h5
`define JFP_IR_PLOAD       4'h6
`define JFP_IR_PREAD       4'h7
`define JFP_IR_PRST        4'hc

// ----------------------------------------------------------------------
// Data register widths and values
// ----------------------------------------------------------------------
`define JFP_EN_W           16
`define JFP_SIG            16'ha370
`define JFP_CMD_W          15
`define JFP_IDX_W          7
`define JFP_PAGE_BYTES     128
`define JFP_BIT_LAST       3'h7

// ----------------------------------------------------------------------
// Timing of the reset time-out on the system clock
// ----------------------------------------------------------------------
`define JFP_CLK_MHZ        25
`define JFP_TOUT_SHORT_US  4000
`define JFP_TOUT_LONG_US   64000
`define JFP_TOUT_W         24

`endif

// ===== jfp_pkg.sv
package jfp_pkg;

    // Instruction register value, four bits wide.
    typedef logic [3:0] jfp_ir_t;

    // Page engine states, one-hot.
    typedef enum logic [2:0] {
        JFP_PG_IDLE = 3'b001,
        JFP_PG_LOAD = 3'b010,
        JFP_PG_READ = 3'b100
    } jfp_pg_e;

endpackage

// ===== jfp_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser; only the second stage is visible outside.
module jfp_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    // ------------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------------
    // The first stage is read by the second stage alone.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ===== jfp_page_ram.sv
`timescale 1ns/1ps
`include "jfp_consts.svh"

// Page buffer of one flash page, with a registered read port.
module jfp_page_ram (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  we,
    input  wire logic [`JFP_IDX_W-1:0] waddr,
    input  wire logic [7:0]            wdata,
    input  wire logic [`JFP_IDX_W-1:0] raddr,
    output logic      [7:0]            rdata
);
    logic [7:0] mem [`JFP_PAGE_BYTES];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Writes land one byte per edge.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data come out of a register one edge after the address.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ===== jfp_prog_model.sv
`timescale 1ns/1ps

// Programmer model: gated TCK at 6 ns, TAP state levels and TDI.
module jfp_prog_model (
    output logic             tck,
    output logic             tdi,
    output jfp_pkg::jfp_ir_t ir,
    output logic             capture_dr,
    output logic             shift_dr,
    output logic             update_dr,
    output logic             run_idle,
    input  wire logic        tdo
);
    // Idle levels; TCK stands still except while tick or the shift loop of scan runs.
    initial begin
        {tck, tdi, capture_dr, shift_dr, update_dr, run_idle} = '0;
        ir = 4'h0;
    end

    // n TCK periods; inputs change only after the falling edge.
    task automatic tick(input int n);
        repeat (n) begin
            #3 tck = 1'b1;
            #3 tck = 1'b0;
        end
    endtask

    // Capture, n shifts LSB first sampling TDO, update, one idle cycle.
    // Used alone on the chain, so page scans are allowed.
    task automatic scan(input jfp_pkg::jfp_ir_t code, input int n,
                        input logic [1031:0] din, input bit idle,
                        output logic [1031:0] dout);
        dout = '0;
        ir = code;
        capture_dr = 1'b1;
        tick(1);
        capture_dr = 1'b0;
        shift_dr = 1'b1;
        for (int i = 0; i < n; i++) begin
            tdi = din[i];
            #3 dout[i] = tdo;
            tck = 1'b1;
            #3 tck = 1'b0;
        end
        shift_dr = 1'b0;
        tdi = ~tdi;
        update_dr = 1'b1;
        tick(1);
        update_dr = 1'b0;
        run_idle = idle;
        tick(1);
        run_idle = 1'b0;
    endtask
endmodule

// ===== jfp_top_tb_top.sv
`timescale 1ns/1ps
`include "jfp_consts.svh"

module jfp_top_tb_top;
    logic                  clk, rst_n, tout_fuse, cmd_result_vld;
    logic [`JFP_CMD_W-1:0] cmd_result, cmd_word;
    logic                  tck, tdi, capture_dr, shift_dr, update_dr;
    logic                  run_idle, tdo, tdo_oe, part_reset;
    logic                  prog_mode, cmd_exec;
    jfp_pkg::jfp_ir_t      ir;
    logic [1031:0]         din, dout;
    int                    n_fail, comparisons, n_exec;

    jfp_top #(.TOUT_SHORT_CYC(8), .TOUT_LONG_CYC(16)) u_jfp_top (
        .clk(clk), .rst_n(rst_n), .tck(tck), .tdi(tdi), .ir(ir),
        .capture_dr(capture_dr), .shift_dr(shift_dr),
        .update_dr(update_dr), .run_idle(run_idle),
        .tout_fuse(tout_fuse), .cmd_result(cmd_result),
        .cmd_result_vld(cmd_result_vld), .tdo(tdo), .tdo_oe(tdo_oe),
        .part_reset(part_reset), .prog_mode(prog_mode),
        .cmd_word(cmd_word), .cmd_exec(cmd_exec));

    jfp_prog_model u_jfp_prog_model (
        .tck(tck), .tdi(tdi), .ir(ir), .capture_dr(capture_dr),
        .shift_dr(shift_dr), .update_dr(update_dr),
        .run_idle(run_idle), .tdo(tdo));

    // System clock of 40 ns.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Counts execute pulses so each idle entry can be checked.
    always @(posedge clk) begin
        if (cmd_exec === 1'b1) n_exec <= n_exec + 1;
    end

    task automatic chk(input string what, input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Sets the time-out fuse, then holds and releases the part reset.
    task automatic t_part_reset(input logic fuse);
        @(negedge clk) tout_fuse = fuse;
        u_jfp_prog_model.scan(`JFP_IR_PRST, 1, 1032'h1, 1'b0, dout);
        chk("rst_set", part_reset, 1);
        repeat (30) @(negedge clk);
        chk("rst_hold", part_reset, 1);
        u_jfp_prog_model.scan(`JFP_IR_PRST, 1, 1032'h0, 1'b0, dout);
        // The long time-out still runs here; the short one is over.
        repeat (14) @(negedge clk);
        chk("rst_tout", part_reset, fuse);
        for (int i = 0; i < 30 && part_reset !== 1'b0; i++) @(negedge clk);
        chk("rst_free", part_reset, 0);
    endtask

    task automatic t_unlock(input logic [15:0] sig, input logic exp);
        u_jfp_prog_model.scan(`JFP_IR_UNLOCK, 16, {1016'h0, sig}, 0, dout);
        repeat (5) @(negedge clk);
        chk("prog_mode", prog_mode, exp);
    endtask

    // Without the unlock neither the update nor the execute may act.
    task automatic t_cmd(input logic [14:0] res, cmd, exp,
                         input bit idle, exe);
        int n0;
        @(negedge clk) cmd_result = res;
        cmd_result_vld = 1'b1;
        @(negedge clk) cmd_result_vld = 1'b0;
        u_jfp_prog_model.tick(4);
        n0 = n_exec;
        u_jfp_prog_model.scan(`JFP_IR_CMD, 15, {1017'h0, cmd}, idle, dout);
        repeat (5) @(negedge clk);
        chk("cmd_out", dout[14:0], res);
        chk("cmd_word", cmd_word, exp);
        chk("cmd_exec", n_exec - n0, exe);
    endtask

    task automatic t_page();
        for (int k = 0; k < 128; k++) din[8*k +: 8] = k[7:0] ^ 8'h5a;
        u_jfp_prog_model.scan(`JFP_IR_PLOAD, 1024, din, 1'b0, dout);
        u_jfp_prog_model.scan(`JFP_IR_PREAD, 1032, '1, 1'b0, dout);
        // The shifter still holds the last loaded byte; it leads the chain.
        chk("pread_lead", dout[7:0], din[1023 -: 8]);
        for (int k = 0; k < 128; k++) begin
            chk("pg_byte", dout[8*k+8 +: 8], din[8*k +: 8]);
        end
    endtask

    // Cuts a hang short.
    initial begin
        #2000000;
        n_fail++;
        tally_and_finish();
    end

    // Reset, then the scenarios in programming order.
    initial begin
        rst_n = 1'b0;
        tout_fuse = 1'b1;
        cmd_result = '0;
        cmd_result_vld = 1'b0;
        u_jfp_prog_model.tick(4);
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        u_jfp_prog_model.tick(4);
        chk("rst_prog", prog_mode, 0);
        chk("rst_oe", tdo_oe, 0);
        t_part_reset(1'b0);
        t_part_reset(1'b1);
        t_cmd(15'h0000, 15'h1234, 15'h0000, 1'b1, 1'b0);
        t_unlock(16'ha371, 1'b0);
        t_unlock(`JFP_SIG, 1'b1);
        t_cmd(15'h5a3c, 15'h2b17, 15'h2b17, 1'b1, 1'b1);
        t_cmd(15'h1c4e, 15'h4c61, 15'h4c61, 1'b0, 1'b0);
        t_page();
        t_unlock(16'h0000, 1'b0);
        tally_and_finish();
    end
endmodule
